// >>> hw/ssio_core.sv
// servo drive sequence input and status output logic with register port
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
module ssio_core (
    input wire logic clock,
    input wire logic reset_n,
    // register port
    input wire logic [ssio_pkg::ADDR_W-1:0] addr,
    input wire logic [ssio_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [ssio_pkg::DATA_W-1:0] rd_data,
    output logic irq,
    // sequence inputs from the host
    input wire logic fwd_torque_select_in_n,
    input wire logic rev_torque_select_in_n,
    input wire logic fault_clear_input_n,
    input wire logic forward_stop_input,
    input wire logic reverse_stop_input,
    // drive internal state
    input wire logic fault_detect,
    input wire logic [ssio_pkg::SPEED_W-1:0] motor_speed,
    input wire logic servo_on_cmd,
    input wire logic prep_done,
    input wire logic main_power_ok,
    input wire logic encoder_index,
    // status outputs
    output logic alt_mode_active,
    output logic fault_output_n,
    output logic motion_detect_output_n,
    output logic drive_ready_output_n,
    output logic index_pulse_output_n,
    output logic travel_limit_output_n,
    output logic [ssio_pkg::NUM_TERM-1:0] term_out_n
);

    // ------------------------------------------------------------------
    // software visible registers
    // ------------------------------------------------------------------
    logic [ssio_pkg::MODE_W-1:0] mode_combination_setting_reg;
    logic [ssio_pkg::TRAVEL_W-1:0] travel_stop_config_reg;
    logic [ssio_pkg::SPEED_W-1:0] speed_threshold_setting_reg;
    logic [ssio_pkg::NUM_TERM*ssio_pkg::CODE_W-1:0] output_assignment_setting_reg;
    logic [ssio_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [ssio_pkg::IRQ_W-1:0] irq_stat_next;
    logic [ssio_pkg::IRQ_W-1:0] irq_mask_reg;
    logic panel_clear_reg;
    logic [ssio_pkg::DATA_W-1:0] rd_data_reg;
    logic irq_reg;

    // ------------------------------------------------------------------
    // status state
    // ------------------------------------------------------------------
    ssio_pkg::ssio_fault_t fault_reg;
    ssio_pkg::ssio_fault_t fault_next;
    logic alt_mode_reg;
    logic fault_out_reg;
    logic motion_reg;
    logic ready_reg;
    logic index_reg;
    logic travel_reg;
    logic travel_prev_reg;
    logic motion_prev_reg;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire sel_ctrl;
    wire sel_speed;
    wire sel_assign;
    wire sel_status;
    wire sel_irq_stat;
    wire sel_irq_mask;

    assign sel_ctrl = (addr == ssio_pkg::CTRL_ADDR);
    assign sel_speed = (addr == ssio_pkg::SPEED_THR_ADDR);
    assign sel_assign = (addr == ssio_pkg::OUT_ASSIGN_ADDR);
    assign sel_status = (addr == ssio_pkg::STATUS_ADDR);
    assign sel_irq_stat = (addr == ssio_pkg::IRQ_STAT_ADDR);
    assign sel_irq_mask = (addr == ssio_pkg::IRQ_MASK_ADDR);

    // ------------------------------------------------------------------
    // control mode switching
    // ------------------------------------------------------------------
    wire mode_in_range;
    wire alt_mode_next;

    // only the combinations with a contact-reference speed side switch here
    assign mode_in_range = (mode_combination_setting_reg >= ssio_pkg::MODE_ALT_LO) &&
                           (mode_combination_setting_reg <= ssio_pkg::MODE_ALT_HI);
    assign alt_mode_next = mode_in_range && fwd_torque_select_in_n &&
                           rev_torque_select_in_n;

    // ------------------------------------------------------------------
    // fault latch
    // ------------------------------------------------------------------
    wire fault_clear_req;

    // the terminal and the panel clear share one path
    assign fault_clear_req = !fault_clear_input_n || panel_clear_reg;

    // detection wins over a clear; a live cause cannot be wiped away
    always_comb
    begin
        case (fault_reg)
            ssio_pkg::SSIO_NORMAL:
                fault_next = fault_detect ? ssio_pkg::SSIO_LATCHED : ssio_pkg::SSIO_NORMAL;
            ssio_pkg::SSIO_LATCHED:
                fault_next = (fault_clear_req && !fault_detect) ?
                             ssio_pkg::SSIO_NORMAL : ssio_pkg::SSIO_LATCHED;
            default:
                fault_next = ssio_pkg::SSIO_LATCHED;
        endcase
    end

    wire fault_active;
    assign fault_active = (fault_reg == ssio_pkg::SSIO_LATCHED);

    // power-up leaves the latch empty without any clear activity
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            fault_reg <= ssio_pkg::SSIO_NORMAL;
        else
            fault_reg <= fault_next;
    end

    // ------------------------------------------------------------------
    // motion detect, ready, index and overtravel
    // ------------------------------------------------------------------
    wire motion_next;
    wire ready_next;
    wire fwd_stop_used;
    wire rev_stop_used;
    wire travel_next;

    // equal speed counts as standing still
    assign motion_next = (motor_speed > speed_threshold_setting_reg);
    assign ready_next = servo_on_cmd && prep_done && main_power_ok &&
                        (fault_next == ssio_pkg::SSIO_NORMAL);
    assign fwd_stop_used = forward_stop_input &&
                           !travel_stop_config_reg[ssio_pkg::TRAVEL_FWD_DIS_DIGIT];
    assign rev_stop_used = reverse_stop_input &&
                           !travel_stop_config_reg[ssio_pkg::TRAVEL_REV_DIS_DIGIT];
    // with both inputs disabled this is constantly zero, output stays on
    assign travel_next = fwd_stop_used || rev_stop_used;

    // status flops; the six dedicated pin levels below are taken from these, the terminals have flops of their own
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            alt_mode_reg <= 1'b0;
            fault_out_reg <= 1'b0;
            motion_reg <= 1'b0;
            ready_reg <= 1'b0;
            index_reg <= 1'b0;
            travel_reg <= 1'b0;
            travel_prev_reg <= 1'b0;
            motion_prev_reg <= 1'b0;
        end
        else
        begin
            alt_mode_reg <= alt_mode_next;
            fault_out_reg <= (fault_next == ssio_pkg::SSIO_LATCHED);
            motion_reg <= motion_next;
            ready_reg <= ready_next;
            index_reg <= encoder_index;
            travel_reg <= travel_next;
            travel_prev_reg <= travel_reg;
            motion_prev_reg <= motion_reg;
        end
    end

    // active-low pins except alt_mode_active, OFF (high) for fault/not ready/not moving
    assign alt_mode_active = alt_mode_reg;
    assign fault_output_n = fault_out_reg;
    assign motion_detect_output_n = !motion_reg;
    assign drive_ready_output_n = !ready_reg;
    assign index_pulse_output_n = !index_reg;
    assign travel_limit_output_n = travel_reg;

    // ------------------------------------------------------------------
    // terminal assignment
    // ------------------------------------------------------------------
    // index width follows the encoder directly, so it shrinks with speed
    ssio_term_map u_term_map (
        .clock(clock),
        .reset_n(reset_n),
        .assign_codes(output_assignment_setting_reg),
        .motion_n(!motion_next),
        .ready_n(!ready_next),
        .index_n(!encoder_index),
        .travel_n(travel_next),
        .term_out_n(term_out_n)
    );

    // ------------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------------
    wire [ssio_pkg::IRQ_W-1:0] irq_events;
    wire irq_stat_rd;

    assign irq_events[ssio_pkg::IRQ_FAULT_SET] = !fault_active &&
                                                (fault_next == ssio_pkg::SSIO_LATCHED);
    assign irq_events[ssio_pkg::IRQ_FAULT_CLR] = fault_active &&
                                                (fault_next == ssio_pkg::SSIO_NORMAL);
    assign irq_events[ssio_pkg::IRQ_MOTION] = motion_reg != motion_prev_reg;
    assign irq_events[ssio_pkg::IRQ_TRAVEL] = travel_reg && !travel_prev_reg;
    assign irq_stat_rd = rd_en && sel_irq_stat;

    // a read clears, but an event in that same cycle survives it
    assign irq_stat_next = (irq_stat_rd ? {ssio_pkg::IRQ_W{1'b0}} : irq_stat_reg) |
                           irq_events;

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // settings written here act on the next cycle, no restart needed
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_combination_setting_reg <= ssio_pkg::MODE_RESET;
            travel_stop_config_reg <= ssio_pkg::TRAVEL_RESET;
            speed_threshold_setting_reg <= ssio_pkg::SPEED_THR_RESET;
            output_assignment_setting_reg <= ssio_pkg::OUT_ASSIGN_RESET;
            irq_mask_reg <= ssio_pkg::IRQ_MASK_RESET;
        end
        else if (wr_en)
        begin
            if (sel_ctrl)
            begin
                mode_combination_setting_reg <=
                    wr_data[ssio_pkg::CTRL_MODE_LSB +: ssio_pkg::MODE_W];
                travel_stop_config_reg <=
                    wr_data[ssio_pkg::CTRL_TRAVEL_LSB +: ssio_pkg::TRAVEL_W];
            end
            if (sel_speed)
                speed_threshold_setting_reg <= wr_data[ssio_pkg::SPEED_W-1:0];
            if (sel_assign)
                output_assignment_setting_reg <=
                    wr_data[ssio_pkg::NUM_TERM*ssio_pkg::CODE_W-1:0];
            if (sel_irq_mask)
                irq_mask_reg <= wr_data[ssio_pkg::IRQ_W-1:0];
        end
    end

    // panel clear is a one-cycle pulse, the bit never reads back
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            panel_clear_reg <= 1'b0;
        else
            panel_clear_reg <= wr_en && sel_ctrl &&
                               wr_data[ssio_pkg::CTRL_PANEL_CLR_BIT];
    end

    // ------------------------------------------------------------------
    // read data mux
    // ------------------------------------------------------------------
    wire [ssio_pkg::DATA_W-1:0] ctrl_word;
    wire [ssio_pkg::DATA_W-1:0] status_word;
    wire [ssio_pkg::DATA_W-1:0] rd_mux;
    wire [ssio_pkg::ST_W-1:0] status_bits;

    assign ctrl_word = {{(ssio_pkg::DATA_W-ssio_pkg::CTRL_TRAVEL_LSB-ssio_pkg::TRAVEL_W){1'b0}},
                        travel_stop_config_reg,
                        {(ssio_pkg::CTRL_TRAVEL_LSB-ssio_pkg::MODE_W){1'b0}},
                        mode_combination_setting_reg};

    // panel display reads the same live status, motion included
    assign status_bits[ssio_pkg::ST_FAULT] = fault_active;
    assign status_bits[ssio_pkg::ST_MOTION] = motion_reg;
    assign status_bits[ssio_pkg::ST_READY] = ready_reg;
    assign status_bits[ssio_pkg::ST_INDEX] = index_reg;
    assign status_bits[ssio_pkg::ST_TRAVEL] = travel_reg;
    assign status_bits[ssio_pkg::ST_ALT_MODE] = alt_mode_reg;
    assign status_word = {{(ssio_pkg::DATA_W-ssio_pkg::ST_W){1'b0}}, status_bits};

    // unmapped addresses read as zero
    assign rd_mux =
        sel_ctrl ? ctrl_word :
        sel_speed ? {{(ssio_pkg::DATA_W-ssio_pkg::SPEED_W){1'b0}},
                     speed_threshold_setting_reg} :
        sel_assign ? {{(ssio_pkg::DATA_W-ssio_pkg::NUM_TERM*ssio_pkg::CODE_W){1'b0}},
                      output_assignment_setting_reg} :
        sel_status ? status_word :
        sel_irq_stat ? {{(ssio_pkg::DATA_W-ssio_pkg::IRQ_W){1'b0}}, irq_stat_reg} :
        sel_irq_mask ? {{(ssio_pkg::DATA_W-ssio_pkg::IRQ_W){1'b0}}, irq_mask_reg} :
        {ssio_pkg::DATA_W{1'b0}};

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            rd_data_reg <= {ssio_pkg::DATA_W{1'b0}};
        else if (rd_en)
            rd_data_reg <= rd_mux;
        else
            rd_data_reg <= {ssio_pkg::DATA_W{1'b0}};
    end

    // sticky status and the level interrupt
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_stat_reg <= {ssio_pkg::IRQ_W{1'b0}};
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= irq_stat_next;
            irq_reg <= |(irq_stat_next & irq_mask_reg);
        end
    end

    assign rd_data = rd_data_reg;
    assign irq = irq_reg;

endmodule

// >>> include/ssio_pkg.sv
// shared constants and types for the servo status and sequence i/o block
package ssio_pkg;

    // ------------------------------------------------------------------
    // register bus geometry and byte offsets
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] SPEED_THR_ADDR = 8'h04;
    localparam logic [7:0] OUT_ASSIGN_ADDR = 8'h08;
    localparam logic [7:0] STATUS_ADDR = 8'h0c;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h10;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h14;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int MODE_W = 4;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_PANEL_CLR_BIT = 4;
    localparam int TRAVEL_W = 4;
    localparam int CTRL_TRAVEL_LSB = 8;
    localparam int TRAVEL_FWD_DIS_DIGIT = 1;
    localparam int TRAVEL_REV_DIS_DIGIT = 2;
    localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
    localparam logic [MODE_W-1:0] MODE_ALT_LO = 4'h4;
    localparam logic [MODE_W-1:0] MODE_ALT_HI = 4'h6;
    localparam logic [TRAVEL_W-1:0] TRAVEL_RESET = 4'h0;

    // ------------------------------------------------------------------
    // speed threshold and output assignment
    // ------------------------------------------------------------------
    localparam int SPEED_W = 16;
    localparam logic [SPEED_W-1:0] SPEED_THR_RESET = 16'h0014;
    localparam int NUM_TERM = 3;
    localparam int CODE_W = 4;
    localparam logic [CODE_W-1:0] OUT_MOTION = 4'h1;
    localparam logic [CODE_W-1:0] OUT_READY = 4'h2;
    localparam logic [CODE_W-1:0] OUT_INDEX = 4'h5;
    localparam logic [CODE_W-1:0] OUT_TRAVEL = 4'h6;
    localparam logic [NUM_TERM*CODE_W-1:0] OUT_ASSIGN_RESET = 12'h021;

    // ------------------------------------------------------------------
    // status and interrupt bit positions
    // ------------------------------------------------------------------
    localparam int ST_W = 6;
    localparam int ST_FAULT = 0;
    localparam int ST_MOTION = 1;
    localparam int ST_READY = 2;
    localparam int ST_INDEX = 3;
    localparam int ST_TRAVEL = 4;
    localparam int ST_ALT_MODE = 5;
    localparam int IRQ_W = 4;
    localparam int IRQ_FAULT_SET = 0;
    localparam int IRQ_FAULT_CLR = 1;
    localparam int IRQ_MOTION = 2;
    localparam int IRQ_TRAVEL = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

    // fault latch states
    typedef enum logic [0:0] {
        SSIO_NORMAL = 1'b0,
        SSIO_LATCHED = 1'b1
    } ssio_fault_t;

endpackage

// >>> hw/ssio_term_map.sv
// routes the selectable active-low status signals onto output terminals
`timescale 1ns/1ns
module ssio_term_map (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [ssio_pkg::NUM_TERM*ssio_pkg::CODE_W-1:0] assign_codes,
    input wire logic motion_n,
    input wire logic ready_n,
    input wire logic index_n,
    input wire logic travel_n,
    output logic [ssio_pkg::NUM_TERM-1:0] term_out_n
);

    // ------------------------------------------------------------------
    // per terminal selection
    // ------------------------------------------------------------------
    genvar t;
    generate
        for (t = 0; t < ssio_pkg::NUM_TERM; t = t + 1)
        begin : g_term
            wire [ssio_pkg::CODE_W-1:0] code;
            wire sel_n;
            assign code = assign_codes[t*ssio_pkg::CODE_W +: ssio_pkg::CODE_W];
            // unknown or unsupported codes park the terminal in its OFF level
            assign sel_n = (code == ssio_pkg::OUT_MOTION) ? motion_n :
                           (code == ssio_pkg::OUT_READY) ? ready_n :
                           (code == ssio_pkg::OUT_INDEX) ? index_n :
                           (code == ssio_pkg::OUT_TRAVEL) ? travel_n : 1'b1;

            // terminals come off a flop so they never glitch on code writes
            always_ff @(posedge clock or negedge reset_n)
            begin
                if (!reset_n)
                    term_out_n[t] <= 1'b1;
                else
                    term_out_n[t] <= sel_n;
            end
        end
    endgenerate

endmodule

// >>> testbench/ssio_core_assertions.sv
// concurrent checks on the status pins of the servo status block
`timescale 1ns/1ns
module ssio_core_assertions (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic wr_en,
    input wire logic fwd_torque_select_in_n,
    input wire logic rev_torque_select_in_n,
    input wire logic fault_clear_input_n,
    input wire logic forward_stop_input,
    input wire logic reverse_stop_input,
    input wire logic fault_detect,
    input wire logic [15:0] motor_speed,
    input wire logic servo_on_cmd,
    input wire logic prep_done,
    input wire logic main_power_ok,
    input wire logic encoder_index,
    input wire logic alt_mode_active,
    input wire logic fault_output_n,
    input wire logic motion_detect_output_n,
    input wire logic drive_ready_output_n,
    input wire logic index_pulse_output_n,
    input wire logic travel_limit_output_n
);
    // ------------------------------------------------------------------
    // pin relations, one clock domain
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // detection and its visible effect, kept apart for reuse
    sequence s_abnormal; fault_detect; endsequence
    sequence s_faulted; fault_output_n && drive_ready_output_n; endsequence
    property p_fault_set; s_abnormal |=> s_faulted; endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault pin not raised");
    // panel clear lands two edges after its write, so both are excluded
    property p_fault_hold;
        fault_output_n && fault_clear_input_n && !wr_en && !$past(wr_en) |=> fault_output_n;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault dropped early");
    property p_fault_clear; !fault_clear_input_n && !fault_detect |=> !fault_output_n; endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");
    property p_alt_off;
        !(fwd_torque_select_in_n && rev_torque_select_in_n) |=> !alt_mode_active;
    endproperty
    a_alt_off: assert property (p_alt_off) else $error("alt mode without both selects");
    property p_motion_idle; motor_speed == 16'h0000 |=> motion_detect_output_n; endproperty
    a_motion_idle: assert property (p_motion_idle) else $error("motion at zero speed");
    property p_ready_off;
        !(servo_on_cmd && prep_done && main_power_ok) |=> drive_ready_output_n;
    endproperty
    a_ready_off: assert property (p_ready_off) else $error("ready without servo on");
    property p_index; 1'b1 |=> index_pulse_output_n == !$past(encoder_index); endproperty
    a_index: assert property (p_index) else $error("index pin mismatch");
    property p_travel_clear;
        !forward_stop_input && !reverse_stop_input |=> !travel_limit_output_n;
    endproperty
    a_travel_clear: assert property (p_travel_clear) else $error("overtravel, no stop");
endmodule

bind ssio_core ssio_core_assertions u_chk (.*);

// >>> testbench/ssio_host_model.sv
// host controller model driving the sequence inputs of the drive
`timescale 1ns/1ns
module ssio_host_model (
    input wire logic clock,
    input wire logic slow,
    input wire logic [4:0] req,
    input wire logic fault_detect,
    input wire logic travel_limit_output_n,
    output logic motion_ref_en,
    output logic fwd_torque_select_in_n,
    output logic rev_torque_select_in_n,
    output logic fault_clear_input_n,
    output logic forward_stop_input,
    output logic reverse_stop_input
);
    logic [4:0] req_d1 = 5'h07;
    logic [4:0] req_d2 = 5'h07;
    logic [4:0] req_use;
    // two stages so the host can answer one cycle later when slow
    always @(posedge clock)
    begin
        req_d1 <= req;
        req_d2 <= req_d1;
    end
    // pin levels: selects, clear, then the two stop inputs
    assign req_use = slow ? req_d2 : req_d1;
    assign fwd_torque_select_in_n = req_use[0];
    assign rev_torque_select_in_n = req_use[1];
    assign fault_clear_input_n = req_use[2] | fault_detect;
    assign forward_stop_input = req_use[3];
    assign reverse_stop_input = req_use[4];
    assign motion_ref_en = !travel_limit_output_n;
endmodule

// >>> testbench/test_ssio_core.sv
// self-checking bench for the servo status and sequence i/o block
`timescale 1ns/1ns
module test_ssio_core;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic fault_detect = 1'b0;
    logic [15:0] motor_speed = 16'h0;
    logic servo_on_cmd = 1'b0;
    logic prep_done = 1'b0;
    logic main_power_ok = 1'b0;
    logic encoder_index = 1'b0;
    logic slow = 1'b0;
    logic [4:0] req = 5'h07;
    logic [31:0] rd_data, got;
    logic irq, alt_mode_active, fault_output_n, motion_detect_output_n, motion_ref_en;
    logic drive_ready_output_n, index_pulse_output_n, travel_limit_output_n;
    logic fwd_torque_select_in_n, rev_torque_select_in_n, fault_clear_input_n;
    logic forward_stop_input, reverse_stop_input;
    logic [2:0] term_out_n, rdy;
    logic [1:0] sel;
    logic [15:0] thr, spd;
    logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h20};
    logic [31:0] rv [5] = '{32'h0, 32'h14, 32'h021, 32'h0, 32'h0};
    logic [3:0] codes [4] = '{4'h1, 4'h2, 4'h5, 4'h6};
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 23330;

    ssio_core dut (.*);
    ssio_host_model host (.*);

    initial forever #10 clock = ~clock;

    // ------------------------------------------------------------------
    // compare, bus and expectation helpers
    // ------------------------------------------------------------------
    task automatic check_bit(input string what, input logic exp, input logic seen);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        @(negedge clock);
        got = rd_data;
    endtask
    // host stages and the output flop
    task automatic settle;
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask
    function automatic logic exp_alt(input logic [3:0] m, input logic [1:0] s);
        return (m >= 4'h4) && (m <= 4'h6) && (s == 2'b11);
    endfunction
    function automatic logic exp_ot(input logic [1:0] dis, input logic [1:0] stop);
        return (stop[0] && !dis[0]) || (stop[1] && !dis[1]);
    endfunction
    task automatic give_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // hang guard, far above the run's length
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        settle;
        check_word("terminals", 32'h7, {29'h0, term_out_n});
        foreach (ra[i])
        begin
            rd(ra[i]);
            check_word("register", rv[i], got);
        end
        // fault, masked then unmasked interrupt, pin and panel clear
        @(posedge clock) fault_detect <= 1'b1;
        settle;
        check_bit("fault set", 1'b1, fault_output_n);
        check_bit("ready in fault", 1'b1, drive_ready_output_n);
        check_bit("masked irq", 1'b0, irq);
        @(posedge clock) fault_detect <= 1'b0;
        settle;
        check_bit("fault latched", 1'b1, fault_output_n);
        wr(8'h14, 32'h1);
        settle;
        check_bit("irq raised", 1'b1, irq);
        rd(8'h10);
        check_word("irq status", 32'h1, got);
        settle;
        check_bit("irq after read", 1'b0, irq);
        @(posedge clock) req <= 5'h03;
        settle;
        check_bit("pin clear", 1'b0, fault_output_n);
        @(posedge clock) req <= 5'h07;
        fault_detect <= 1'b1;
        @(posedge clock) fault_detect <= 1'b0;
        wr(8'h00, 32'h10);
        settle;
        check_bit("panel clear", 1'b0, fault_output_n);
        // all modes, selects high then random
        for (int m = 0; m < 32; m++)
        begin
            sel = (m < 16) ? 2'b11 : 2'($random(seed));
            wr(8'h00, 32'(m % 16));
            @(posedge clock) req <= {3'b001, sel};
            slow <= 1'($random(seed));
            settle;
            check_bit("alt mode", exp_alt(4'(m % 16), sel), alt_mode_active);
        end
        // threshold edge, then random speed
        for (int i = 0; i < 24; i++)
        begin
            thr = (i < 2) ? 16'h0014 : 16'($random(seed));
            spd = (i == 0) ? 16'h0014 : (i == 1) ? 16'h0015 : 16'($random(seed));
            rdy = (i == 2) ? 3'b111 : 3'($random(seed));
            wr(8'h04, {16'h0, thr});
            @(posedge clock) motor_speed <= spd;
            {servo_on_cmd, prep_done, main_power_ok} <= rdy;
            encoder_index <= i[0];
            settle;
            check_bit("motion", !(spd > thr), motion_detect_output_n);
            check_bit("ready", !(rdy == 3'b111), drive_ready_output_n);
            check_bit("index", !i[0], index_pulse_output_n);
            rd(8'h0c);
            check_bit("motion status", spd > thr, got[1]);
        end
        // disable digits against stop inputs
        for (int i = 0; i < 16; i++)
        begin
            wr(8'h00, {20'h0, 1'b0, i[3:2], 1'b0, 8'h00});
            @(posedge clock) req <= {i[1], i[0], 3'b111};
            settle;
            check_bit("travel", exp_ot(i[3:2], i[1:0]), travel_limit_output_n);
        end
        // each code on terminal two
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h14);
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h08, {20'h0, codes[c / 2], 8'h00});
            @(posedge clock) motor_speed <= c[0] ? 16'hffff : 16'h0;
            {servo_on_cmd, prep_done, main_power_ok} <= {3{c[0]}};
            encoder_index <= c[0];
            req <= {1'b0, c[0], 3'b111};
            settle;
            check_bit("terminal", (c / 2 == 3) ? c[0] : !c[0], term_out_n[2]);
        end
        // power cycle with a fault latched
        @(posedge clock) fault_detect <= 1'b1;
        @(posedge clock) reset_n <= 1'b0;
        fault_detect <= 1'b0;
        @(posedge clock) reset_n <= 1'b1;
        settle;
        check_bit("fault after power up", 1'b0, fault_output_n);
        give_verdict();
    end
endmodule
